// ==== ssr_serial_status_return.sv ====
`timescale 1ns/1ps
// Functional notes
// [R1] Select low loads the 16-bit status word; SO shifts it MSB first.
// [R2] First 16 returned bits depend on the previous valid command.
// [R3] Bits past the first 16 replay SI bits received since select fell.
// [R4] On select rising, only whole multiples of 16 bits are accepted.
// [R5] Select high tri-states SO and lets fault capture update again.
// [R6] Upper two code bits pick the output for output-specific sources.
// [R7] Chosen source and output persist until the next status select command.
// [R8] A rejected transfer leaves reported status untouched.
// [R9] Host ignores the first word after an undervoltage shutdown.
// [R10] Host ignores the first word after reset rises with wake low.
// [R11] Bit 15 echoes the watchdog toggle of the previous command.
// [R12] Bit 14 flags undervoltage, bit 13 overvoltage, otherwise zero.
// [R13] Bits 12 to 8 echo the stored status select code.
// [R14] Bits 7 to 4 carry fault summaries of outputs 3 to 0.
// [R15] Code pair-000 returns chosen output temperature, current and open-load faults.
// [R16] Code 00001 returns serial on commands of outputs 3 to 0.
// [R17] Code 01001 returns active-low current sense enables of outputs 3 to 0.
// [R18] Code pair-010 returns high level bit then three low level bits.
// [R19] Code pair-011 returns open-load disable, low detect disable, two blanking bits.
// [R20] Fault pin shows every fault; latched ones clear on a switch-off command.
// [R21] Code pair-100 returns slew, sense ratio, direct disable, and/or settings.
// [R22] Code 01101 returns watchdog expired on bit 2, period on bits 1-0.
// [R23] Code 00110 returns fail-safe states, watchdog enabled and wake level.
// [R24] Code 01110 returns the four direct input pin levels.
// [R25] After reset the select code and status word read zero until a command.
module ssr_serial_status_return (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       sclk,
  input  wire logic                       csN,
  input  wire logic                       si,
  output logic                            so,
  output logic                            soOe,
  input  wire ssr_pkg::ssr_fault_t [3:0]  outputFaultFlags,
  input  wire logic [3:0]                 outputFaultSummary,
  input  wire logic                       undervoltageFlag,
  input  wire logic                       overvoltageFlag,
  input  wire ssr_pkg::ssr_out_cfg_t [3:0] outCfg,
  input  wire ssr_pkg::ssr_dev_cfg_t      devCfg,
  input  wire logic                       wakePin,
  input  wire logic [3:0]                 directIn,
  output logic                            faultPinN,
  output logic [15:0]                     cmdWord,
  output logic                            cmdStrobe
);
  import ssr_pkg::*;

  ssr_link_t   link;
  logic [15:0] statusWord_q;
  logic [15:0] statusWord_d;
  logic [5:0]  pinSync;
  logic        togSync;
  logic        csS;
  logic        wakeS;
  logic [3:0]  dirS;
  logic        csPrev_q;
  logic        togSeen_q;
  logic        csRise;
  logic        frameHadBits;
  logic        validLen;
  logic        take;
  logic        isStatusSelect;
  logic [15:0] cmdWord_q;
  logic        cmdStrobe_q;
  logic        cmdSeen_q;
  logic        wdEcho_q;
  logic [4:0]  selCode_q;
  logic        uvSticky_q;
  logic        ovSticky_q;
  logic [3:0]  faultLatch_q;
  logic [3:0]  dirPrev_q;
  logic [3:0]  serialPrev_q;
  logic [3:0]  serialOnV;
  logic [3:0]  senseEnNV;
  logic [3:0]  faultAny;
  logic [1:0]  pairSel;
  ssr_out_cfg_t selCfg;
  ssr_fault_t  selFault;
  logic [3:0]  tail;

  // Link-clock side: shifting, replay and bit counting
  ssr_link_shifter u_link (
    .sclk       (sclk),
    .rst_n      (rst_n),
    .csN        (csN),
    .si         (si),
    .statusWord (statusWord_q),
    .so         (so),
    .soOe       (soOe),
    .link       (link)
  );

  // Pins into mclk; select idles high
  ssr_sync #(.WIDTH(6), .RESET_VAL(6'h20)) u_pin_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn ({csN, wakePin, directIn}),
    .syncOut (pinSync)
  );

  // Frame toggle: tells a frame with clocks from one without any
  ssr_sync #(.WIDTH(1), .RESET_VAL(1'h0)) u_tog_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn (link.frameTog),
    .syncOut (togSync)
  );

  assign csS   = pinSync[5];
  assign wakeS = pinSync[4];
  assign dirS  = pinSync[3:0];

  // Frame end detection; link words are quiet by the time the synced edge shows
  assign csRise         = csS && !csPrev_q;
  assign frameHadBits   = togSync != togSeen_q;
  assign validLen       = frameHadBits && (link.bitLow == 4'h0) && link.longFrame;  // [R4]
  assign take           = csRise && validLen;
  assign isStatusSelect = link.rxWord[CMD_ADDR_MSB:CMD_ADDR_LSB] == STATUS_SELECT_ADDR;

  // Edge history of select and toggle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      csPrev_q  <= 1'b1;
      togSeen_q <= 1'b0;
    end else begin
      csPrev_q <= csS;
      if (csRise) begin
        togSeen_q <= togSync;
      end
    end
  end

  // Accepted command goes out for the configuration decode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmdWord_q   <= WORD_RESET;
      cmdStrobe_q <= 1'b0;
      cmdSeen_q   <= 1'b0;
      wdEcho_q    <= 1'b0;
    end else begin
      cmdStrobe_q <= take;  // [R4] [R8]
      if (take) begin
        cmdWord_q <= link.rxWord;
        cmdSeen_q <= 1'b1;
        wdEcho_q  <= link.rxWord[CMD_WD_POS];  // [R11]
      end
    end
  end

  assign cmdWord   = cmdWord_q;
  assign cmdStrobe = cmdStrobe_q;

  // Select code changes only on an accepted status select command
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      selCode_q <= CODE_RESET;  // [R25]
    end else if (take && isStatusSelect) begin
      selCode_q <= link.rxWord[CMD_CODE_MSB:0];  // [R7] [R8]
    end
  end

  // Voltage flags stay set until a valid transfer has carried them out
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      uvSticky_q <= 1'b0;
      ovSticky_q <= 1'b0;
    end else begin
      uvSticky_q <= undervoltageFlag || (uvSticky_q && !take);  // [R12]
      ovSticky_q <= overvoltageFlag || (ovSticky_q && !take);  // [R12]
    end
  end

  // Per output: fault latch for the pin and gathered setting bits
  for (genvar i = 0; i < OUT_COUNT; i++) begin : g_out
    assign faultAny[i]  = |outputFaultFlags[i];
    assign serialOnV[i] = outCfg[i].serialOn;
    assign senseEnNV[i] = outCfg[i].senseEnN;

    // Set wins over a switch-off seen in the same cycle
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        faultLatch_q[i] <= 1'b0;
        dirPrev_q[i]    <= 1'b0;
        serialPrev_q[i] <= 1'b0;
      end else begin
        dirPrev_q[i]    <= dirS[i];
        serialPrev_q[i] <= serialOnV[i];
        if (faultAny[i]) begin
          faultLatch_q[i] <= 1'b1;
        end else if ((dirPrev_q[i] && !dirS[i]) || (serialPrev_q[i] && !serialOnV[i])) begin
          faultLatch_q[i] <= 1'b0;  // [R20]
        end
      end
    end
  end

  // Pin is active low and covers voltage faults too
  assign faultPinN = !(|faultLatch_q || |faultAny || undervoltageFlag || overvoltageFlag);  // [R20]

  // Chosen output for output-specific sources
  assign pairSel  = selCode_q[4:3];
  assign selCfg   = outCfg[pairSel];  // [R6]
  assign selFault = outputFaultFlags[pairSel];  // [R6]

  // Low nibble by source; unknown codes read zero
  always_comb begin
    tail = 4'h0;
    case (selCode_q[2:0])
      SRC_FAULT:  tail = selFault;  // [R15]
      SRC_LEVEL:  tail = {selCfg.highLevel, selCfg.lowLevel};  // [R18]
      SRC_BLANK:  tail = {selCfg.openLoadDisable, selCfg.lowDetectDisable, selCfg.blankTime};  // [R19]
      SRC_DIRECT: tail = {selCfg.fastSlew, selCfg.highSenseRatio, selCfg.directDisable,
                          selCfg.andCombine};  // [R21]
      default: begin
        case (selCode_q)
          CODE_SERIAL_ON: tail = serialOnV;  // [R16]
          CODE_SENSE_EN:  tail = senseEnNV;  // [R17]
          CODE_VOLTAGE:   tail = {devCfg.overTempLatch10, devCfg.uvDisable, devCfg.ovDisable};
          CODE_WATCHDOG:  tail = {1'b0, devCfg.wdExpired, devCfg.wdPeriod};  // [R22]
          CODE_PIN0:      tail = {devCfg.failsafeHs2, devCfg.failsafeHs0, devCfg.wdEnabled, wakeS};  // [R23]
          CODE_PIN1:      tail = dirS;  // [R24]
          CODE_PIN2:      tail = {devCfg.overTempLatch32, 2'h0};
          default:        tail = 4'h0;
        endcase
      end
    endcase
  end

  // Word assembly
  always_comb begin
    statusWord_d                    = WORD_RESET;
    statusWord_d[WD_POS]            = wdEcho_q;  // [R11]
    statusWord_d[UV_POS]            = uvSticky_q;  // [R12]
    statusWord_d[OV_POS]            = ovSticky_q;  // [R12]
    statusWord_d[CODE_MSB:CODE_LSB] = selCode_q;  // [R13]
    statusWord_d[SUM_MSB:SUM_LSB]   = outputFaultSummary;  // [R14]
    statusWord_d[3:0]               = tail;
  end

  // Frozen while select is low so the link reads a steady word;
  // capture resumes once select is high again
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      statusWord_q <= WORD_RESET;  // [R25]
    end else if (csS) begin
      statusWord_q <= cmdSeen_q ? statusWord_d : WORD_RESET;  // [R2] [R5] [R25]
    end
  end

  property p_reset_zero;
    @(posedge mclk) disable iff (!rst_n)
    !cmdSeen_q |=> statusWord_q == WORD_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero)  // [R25]
    else $error("status word not zero before first command");

  property p_latch_cmd;
    @(posedge mclk) disable iff (!rst_n)
    take |=> cmdStrobe_q && (cmdWord_q == $past(link.rxWord));
  endproperty
  a_latch_cmd: assert property (p_latch_cmd)  // [R4]
    else $error("valid frame not latched");

  property p_invalid;
    @(posedge mclk) disable iff (!rst_n)
    csRise && !validLen |=> $stable(selCode_q) && $stable(wdEcho_q) && !cmdStrobe_q;
  endproperty
  a_invalid: assert property (p_invalid)  // [R8]
    else $error("invalid frame changed state");

  property p_keep_select;
    @(posedge mclk) disable iff (!rst_n)
    !(take && isStatusSelect) |=> $stable(selCode_q);
  endproperty
  a_keep_select: assert property (p_keep_select)  // [R7]
    else $error("select code changed without command");

  property p_freeze;
    @(posedge mclk) disable iff (!rst_n)
    !csS |=> $stable(statusWord_q);
  endproperty
  a_freeze: assert property (p_freeze)  // [R5]
    else $error("status word moved during frame");

  property p_wd_echo;
    @(posedge mclk) disable iff (!rst_n)
    take ##1 csS [*2] |-> statusWord_q[WD_POS] == cmdWord_q[CMD_WD_POS];
  endproperty
  a_wd_echo: assert property (p_wd_echo)  // [R11]
    else $error("watchdog echo wrong");

  property p_code_echo;
    @(posedge mclk) disable iff (!rst_n)
    csS && cmdSeen_q |=> statusWord_q[CODE_MSB:CODE_LSB] == $past(selCode_q);
  endproperty
  a_code_echo: assert property (p_code_echo)  // [R13]
    else $error("code echo wrong");

  property p_summary;
    @(posedge mclk) disable iff (!rst_n)
    csS && cmdSeen_q |=> statusWord_q[SUM_MSB:SUM_LSB] == $past(outputFaultSummary);
  endproperty
  a_summary: assert property (p_summary)  // [R14]
    else $error("fault summary wrong");

  property p_uv_clear;
    @(posedge mclk) disable iff (!rst_n)
    csS && cmdSeen_q && !uvSticky_q |=> !statusWord_q[UV_POS];
  endproperty
  a_uv_clear: assert property (p_uv_clear)  // [R12]
    else $error("undervoltage bit set without cause");

  property p_fault_tail;
    @(posedge mclk) disable iff (!rst_n)
    csS && cmdSeen_q && (selCode_q[2:0] == SRC_FAULT) |=> statusWord_q[3:0] == $past(selFault);
  endproperty
  a_fault_tail: assert property (p_fault_tail)  // [R15]
    else $error("selected fault flags wrong");

  property p_fault_pin;
    @(posedge mclk) disable iff (!rst_n)
    |faultAny |=> !faultPinN;
  endproperty
  a_fault_pin: assert property (p_fault_pin)  // [R20]
    else $error("fault pin not asserted");
endmodule // ssr_serial_status_return

// ==== ssr_pkg.sv ====
package ssr_pkg;

  // Word geometry
  localparam int WORD_BITS = 16;
  localparam int OUT_COUNT = 4;

  // Status word bit positions
  localparam int WD_POS    = 15;
  localparam int UV_POS    = 14;
  localparam int OV_POS    = 13;
  localparam int CODE_MSB  = 12;
  localparam int CODE_LSB  = 8;
  localparam int SUM_MSB   = 7;
  localparam int SUM_LSB   = 4;

  // Command word fields
  localparam int CMD_WD_POS   = 15;
  localparam int CMD_ADDR_MSB = 12;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_CODE_MSB = 4;
  localparam logic [4:0] STATUS_SELECT_ADDR = 5'h00;

  // Output-specific sources, low three code bits
  localparam logic [2:0] SRC_FAULT  = 3'h0;
  localparam logic [2:0] SRC_LEVEL  = 3'h2;
  localparam logic [2:0] SRC_BLANK  = 3'h3;
  localparam logic [2:0] SRC_DIRECT = 3'h4;

  // Device-wide sources, full code
  localparam logic [4:0] CODE_SERIAL_ON = 5'h01;
  localparam logic [4:0] CODE_SENSE_EN  = 5'h09;
  localparam logic [4:0] CODE_VOLTAGE   = 5'h05;
  localparam logic [4:0] CODE_WATCHDOG  = 5'h0d;
  localparam logic [4:0] CODE_PIN0      = 5'h06;
  localparam logic [4:0] CODE_PIN1      = 5'h0e;
  localparam logic [4:0] CODE_PIN2      = 5'h0f;

  // Values after reset
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [4:0]  CODE_RESET = 5'h00;

  // Fault flags of one output, in returned bit order 3..0
  typedef struct packed {
    logic overTemp;
    logic highOc;
    logic lowOc;
    logic openLoad;
  } ssr_fault_t;

  // Programmed settings of one output
  typedef struct packed {
    logic       highLevel;
    logic [2:0] lowLevel;
    logic       openLoadDisable;
    logic       lowDetectDisable;
    logic [1:0] blankTime;
    logic       fastSlew;
    logic       highSenseRatio;
    logic       directDisable;
    logic       andCombine;
    logic       serialOn;
    logic       senseEnN;
  } ssr_out_cfg_t;

  // Device-wide settings and states
  typedef struct packed {
    logic [1:0] overTempLatch10;
    logic       uvDisable;
    logic       ovDisable;
    logic [1:0] overTempLatch32;
    logic [1:0] wdPeriod;
    logic       wdExpired;
    logic       wdEnabled;
    logic       failsafeHs2;
    logic       failsafeHs0;
  } ssr_dev_cfg_t;

  // Frame results handed from the link clock to mclk
  typedef struct packed {
    logic [15:0] rxWord;
    logic [3:0]  bitLow;
    logic        longFrame;
    logic        frameTog;
  } ssr_link_t;

endpackage

// ==== ssr_sync.sv ====
`timescale 1ns/1ps
module ssr_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage_q;

  if (WIDTH < 1) begin : g_check
    $error("ssr_sync needs at least one bit");
  end

  // Two stages; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage_q <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage_q <= asyncIn;
      syncOut <= stage_q;
    end
  end
endmodule // ssr_sync

// ==== ssr_link_shifter.sv ====
`timescale 1ns/1ps
module ssr_link_shifter (
  input  wire logic              sclk,
  input  wire logic              rst_n,
  input  wire logic              csN,
  input  wire logic              si,
  input  wire logic [15:0]       statusWord,
  output logic                   so,
  output logic                   soOe,
  output ssr_pkg::ssr_link_t     link
);
  import ssr_pkg::*;

  logic        fresh_q;
  logic [15:0] rx_q;
  logic [3:0]  cnt_q;
  logic        long_q;
  logic        tog_q;
  logic        linkClr;
  logic        freshSet;
  logic [3:0]  bitIdx;

  // The link clock stands still between frames, so clears are asynchronous
  assign linkClr  = !rst_n;
  assign freshSet = csN | linkClr;

  // Marks a frame that has not yet seen its first edge
  always_ff @(posedge sclk or posedge freshSet) begin
    if (freshSet) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // Receive shifter and bit count modulo sixteen
  always_ff @(posedge sclk or posedge linkClr) begin
    if (linkClr) begin
      rx_q   <= WORD_RESET;
      cnt_q  <= 4'h0;
      long_q <= 1'b0;
      tog_q  <= 1'b0;
    end else begin
      rx_q <= {rx_q[14:0], si};  // [R1]
      if (fresh_q) begin
        cnt_q  <= 4'h1;
        long_q <= 1'b0;
        tog_q  <= ~tog_q;
      end else begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'hf) begin
          long_q <= 1'b1;
        end
      end
    end
  end

  // First sixteen bits from the frozen word MSB first, then replay of SI
  assign bitIdx = fresh_q ? 4'h0 : cnt_q;
  assign so     = (fresh_q || !long_q) ? statusWord[4'hf - bitIdx] : rx_q[15];  // [R1] [R2] [R3]
  assign soOe   = !csN;  // [R5]

  // Held stable once the select rises; core reads it after a synced edge
  assign link = '{rxWord: rx_q, bitLow: cnt_q, longFrame: long_q, frameTog: tog_q};
endmodule // ssr_link_shifter

// ==== ssr_host_model.sv ====
`timescale 1ns/1ps
// Host master: clocks frames MSB first, clock stands still between frames
module ssr_host_model (
  output logic      sclk,
  output logic      csN,
  output logic      si,
  input  wire logic so,
  input  wire logic soOe
);
  localparam realtime HALF = 62.5;
  logic soLine;
  logic lastSo = 1'b0;

  // No pull on the data line: once released it reads the inverse of the last bit
  always @(so or soOe) if (soOe) lastSo = so;
  assign soLine = soOe ? so : ~lastSo;

  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    si   = 1'b0;
  end

  // Select leads the first edge by 102.5 ns so the device can freeze its word.
  // Callers never rely on the word after an undervoltage shutdown;
  // the test checks that the first word after a reset release with wake low reads zero
  task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = '0;
    csN = 1'b0;
    #40;
    for (int i = nbits - 1; i >= 0; i--) begin
      si = tx[i];
      #HALF;
      rx[i] = soLine;
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
    end
    #40;
    csN = 1'b1;
    si = ~si;
    #1;
  endtask
endmodule // ssr_host_model

// ==== test_serial_status_return.sv ====
`timescale 1ns/1ps
// Host frames in, status words out, compared with values built here
module test_serial_status_return;
  import ssr_pkg::*;
  logic               mclk, rst_n, sclk, csN, si, so, soOe, faultPinN, cmdStrobe;
  logic [15:0]        cmdWord, tx;
  logic [31:0]        rx;
  logic [3:0]         outputFaultSummary, directIn;
  logic               undervoltageFlag, overvoltageFlag, wakePin;
  ssr_fault_t [3:0]   outputFaultFlags;
  ssr_out_cfg_t [3:0] outCfg;
  ssr_dev_cfg_t       devCfg;
  int                 n_errors = 0, checks = 0, strobes = 0, s0;
  int                 bad [3] = '{0, 12, 17};
  // Each frame selects the next code and reports the one before; 05, 0f and an unused 07 included
  logic [4:0] codes [24] = '{5'h00, 5'h08, 5'h10, 5'h18, 5'h01, 5'h09, 5'h02, 5'h0a, 5'h12, 5'h1a,
    5'h03, 5'h0b, 5'h13, 5'h1b, 5'h04, 5'h0c, 5'h14, 5'h1c, 5'h05, 5'h0f, 5'h07, 5'h0d, 5'h06, 5'h0e};

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Accepted frames are counted so refused ones that slip through show up
  always @(posedge mclk) if (cmdStrobe === 1'b1) strobes++;

  ssr_serial_status_return dut (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .si(si), .so(so), .soOe(soOe),
    .outputFaultFlags(outputFaultFlags), .outputFaultSummary(outputFaultSummary),
    .undervoltageFlag(undervoltageFlag), .overvoltageFlag(overvoltageFlag), .outCfg(outCfg),
    .devCfg(devCfg), .wakePin(wakePin), .directIn(directIn), .faultPinN(faultPinN),
    .cmdWord(cmdWord), .cmdStrobe(cmdStrobe)
  );

  ssr_host_model host (.sclk(sclk), .csN(csN), .si(si), .so(so), .soOe(soOe));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [15:0] selCmd(input logic wd, input logic [4:0] c);
    return {wd, 2'b00, STATUS_SELECT_ADDR, 3'b000, c};
  endfunction

  function automatic logic [15:0] nop(input logic wd);
    return {wd, 2'b00, 5'h06, 8'h00};
  endfunction

  // Low nibble expected for a stored select code
  function automatic logic [3:0] expLow(input logic [4:0] c);
    ssr_out_cfg_t o;
    logic [3:0]   on, en;
    o = outCfg[c[4:3]];
    for (int i = 0; i < 4; i++) begin
      on[i] = outCfg[i].serialOn;
      en[i] = outCfg[i].senseEnN;
    end
    case (c)
      CODE_SERIAL_ON: return on;
      CODE_SENSE_EN: return en;
      CODE_WATCHDOG: return {1'b0, devCfg.wdExpired, devCfg.wdPeriod};
      CODE_PIN0: return {devCfg.failsafeHs2, devCfg.failsafeHs0, devCfg.wdEnabled, wakePin};
      CODE_PIN1: return directIn;
      CODE_VOLTAGE: return {devCfg.overTempLatch10, devCfg.uvDisable, devCfg.ovDisable};
      CODE_PIN2: return {devCfg.overTempLatch32, 2'h0};
      default: ;
    endcase
    case (c[2:0])
      SRC_FAULT: return outputFaultFlags[c[4:3]];
      SRC_LEVEL: return {o.highLevel, o.lowLevel};
      SRC_BLANK: return {o.openLoadDisable, o.lowDetectDisable, o.blankTime};
      SRC_DIRECT: return {o.fastSlew, o.highSenseRatio, o.directDisable, o.andCombine};
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [15:0] expWord(input logic wd, input logic [4:0] c, input logic [1:0] uvov);
    return {wd, uvov, c, outputFaultSummary, expLow(c)};
  endfunction

  // One frame, then the gap that lets the word refresh
  task automatic xfer(input logic [31:0] t, input int n);
    host.frame(t, n, rx);
    check("output enable", 32'h0, {31'h0, soOe});
    repeat (20) @(posedge mclk);
  endtask

  task automatic step(input logic [15:0] t, input logic [4:0] c, input logic [1:0] uvov);
    logic [15:0] p;
    p = tx;
    tx = t;
    xfer({16'h0, t}, 16);
    check("status", {16'h0, expWord(p[15], c, uvov)}, rx);
    check("command", {16'h0, t}, {16'h0, cmdWord});
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    outputFaultFlags = '0;
    outputFaultSummary = 4'h0;
    directIn = 4'h0;
    wakePin = 1'b0;
    undervoltageFlag = 1'b0;
    overvoltageFlag = 1'b0;
    outCfg = '0;
    devCfg = '0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    check("command after reset", 32'h0, {16'h0, cmdWord});
    tx = selCmd(1'b1, codes[0]);
    xfer({16'h0, tx}, 16);
    check("first status", 32'h0, rx);
    @(posedge mclk);
    outputFaultSummary <= 4'ha;
    outputFaultFlags <= 16'h9c36;
    directIn <= 4'h6;
    wakePin <= 1'b1;
    outCfg <= 56'h9c5a3e71b4c2d9;
    devCfg <= 12'h85d;
    repeat (8) @(posedge mclk);
    check("fault pin", 32'h0, {31'h0, faultPinN});
    for (int i = 1; i < 24; i++) step(selCmd(i[0], codes[i]), codes[i - 1], 2'b00);
    // Voltage flags stay up until the next accepted frame
    undervoltageFlag <= 1'b1;
    overvoltageFlag <= 1'b1;
    @(posedge mclk);
    undervoltageFlag <= 1'b0;
    overvoltageFlag <= 1'b0;
    repeat (4) @(posedge mclk);
    step(nop(1'b1), 5'h0e, 2'b11);
    step(nop(1'b0), 5'h0e, 2'b00);
    // Refused lengths: empty, short, one bit over
    foreach (bad[k]) begin
      s0 = strobes;
      xfer({16'h0, selCmd(1'b1, 5'h01)}, bad[k]);
      check("refused strobe", s0, strobes);
      step(nop(k[0]), 5'h0e, 2'b00);
    end
    // Two words in one frame: the second half replays what went in
    s0 = strobes;
    xfer({16'ha5c3, selCmd(1'b0, 5'h02)}, 32);
    check("replay", 32'ha5c3, {16'h0, rx[15:0]});
    check("word before replay", {16'h0, expWord(tx[15], 5'h0e, 2'b00)}, {16'h0, rx[31:16]});
    check("long frame strobe", s0 + 1, strobes);
    tx = selCmd(1'b0, 5'h02);
    check("long frame command", {16'h0, tx}, {16'h0, cmdWord});
    step(nop(1'b1), 5'h02, 2'b00);
    // Latched faults hold the pin until the direct inputs switch off
    directIn <= 4'hf;
    repeat (6) @(posedge mclk);
    outputFaultFlags <= '0;
    outputFaultSummary <= 4'h0;
    repeat (6) @(posedge mclk);
    check("latched fault pin", 32'h0, {31'h0, faultPinN});
    directIn <= 4'h0;
    repeat (8) @(posedge mclk);
    check("released fault pin", 32'h1, {31'h0, faultPinN});
    // A serial switch-off of output 1 releases its latched fault too
    outputFaultFlags <= 16'h0010;
    repeat (2) @(posedge mclk);
    outputFaultFlags <= '0;
    repeat (6) @(posedge mclk);
    check("relatched fault pin", 32'h0, {31'h0, faultPinN});
    outCfg[1].serialOn <= 1'b0;
    repeat (6) @(posedge mclk);
    check("serial off fault pin", 32'h1, {31'h0, faultPinN});
    give_verdict();
  end
endmodule // test_serial_status_return
